// ### src/efisp_device.sv
`timescale 1ns/1ps
`include "efisp_cfg.svh"
module efisp_device #(
   parameter int unsigned ERASE_CYCLES = `EFISP_ERASE_CYC,       // Erase duration in clocks
   parameter logic [31:0] COMPANY_ID   = 32'h0000_0c3a,           // Arbitrary value
   parameter logic [95:0] UNIQUE_ID    = 96'h1357_9bdf_2468_ace0_0f1e_2d3c, // Arbitrary value
   parameter logic [31:0] CFG_DEFAULT  = 32'hffff_ffff            // Config word at power-on
) (
   input  wire logic mclk_i,          // System clock
   input  wire logic reset_i,         // Power-on reset
   efisp_if.dev      bus,             // Core side
   output logic [31:0] user_config_o, // Loaded config word
   output logic        booted_loader_o, // Running from loader
   output logic        busy_o          // Command in progress
);
   import efisp_pkg::*;

   localparam logic [16:0] READ_C = 17'(`EFISP_READ_CYC);
   localparam logic [16:0] PROG_C = 17'(`EFISP_PROG_CYC);

   logic [31:0] main_mem [0:32767];
   logic [31:0] ldr_mem  [0:1023];
   logic [31:0] cfg_mem  [0:1];

   efisp_dev_state_t state;
   logic        prog_en, boot_sel, app_upd, cfg_upd, ldr_upd, prog_fail_flag;
   logic        prog_go_bit, app_erased;
   logic [31:0] prog_address_reg, prog_data_reg;
   logic [5:0]  prog_command_reg;
   logic [1:0]  key_state;
   logic [16:0] cnt;
   logic [7:0]  eidx;
   logic [31:0] rdata, fdata;

   wire logic        take   = bus.reg_sel && bus.reg_ready;
   wire logic        wr     = take && bus.reg_we;
   wire logic        unlock = (key_state == 2'd3);
   wire logic        go_wr  = wr && unlock && (bus.reg_addr == `EFISP_OFS_TRIG)
                              && bus.reg_wdata[`EFISP_TRIG_GO];
   wire logic        operation_enable  = prog_command_reg[5];
   wire logic        chip_enable_field = prog_command_reg[4];
   wire logic [3:0]  function_code     = prog_command_reg[3:0];
   wire logic [31:0] a = prog_address_reg;

   // Region decode of the command address
   wire logic t_cfg  = a[21] && a[20] && (a[31:22] == 10'h0) && (a[19:3] == 17'h0);
   wire logic t_main = !a[21] && (a[31:22] == 10'h0);
   wire logic t_app  = t_main && !a[20] && (a[31:16] == `EFISP_APP_HI);
   wire logic t_data = t_main && !a[20] && (a[31:12] == `EFISP_DATA_TAG);
   wire logic t_ldr  = t_main && a[20] && (a[31:12] == `EFISP_LDR_TAG);
   wire logic t_ok   = t_cfg || t_app || t_data || t_ldr;

   wire logic is_read  = !operation_enable && !chip_enable_field && function_code == `EFISP_FN_READ;
   wire logic is_prog  = operation_enable && !chip_enable_field && function_code == `EFISP_FN_PROG;
   wire logic is_erase = operation_enable && !chip_enable_field && function_code == `EFISP_FN_ERASE;
   wire logic is_uid   = !operation_enable && !chip_enable_field && function_code == `EFISP_FN_UID;
   wire logic is_cid   = !operation_enable && !chip_enable_field && function_code == `EFISP_FN_CID;
   wire logic is_write = is_prog || is_erase;

   logic err;
   always_comb begin
      err = 1'b0;
      if (!prog_en)
         err = 1'b1;
      if (!(is_read || is_write || is_uid || is_cid))
         err = 1'b1;
      if ((is_read || is_write) && !t_ok)
         err = 1'b1;
      if (is_write && t_app && !booted_loader_o && !app_upd)
         err = 1'b1;
      if (is_write && t_ldr && (booted_loader_o || !ldr_upd))
         err = 1'b1;
      if (is_write && t_cfg && !cfg_upd)
         err = 1'b1;
      if (is_erase && t_cfg && !app_erased)
         err = 1'b1;
      if (is_uid && (a[31:4] != 28'h0 || a[3:2] == 2'b11 || a[1:0] != 2'b00))
         err = 1'b1;
   end

   // Write-protect key sequence; any other write to the key register relocks
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         key_state <= 2'd0;
      end else if (wr && bus.reg_addr == `EFISP_OFS_KEY) begin
         if (key_state == 2'd0 && bus.reg_wdata[7:0] == `EFISP_KEY0)
            key_state <= 2'd1;
         else if (key_state == 2'd1 && bus.reg_wdata[7:0] == `EFISP_KEY1)
            key_state <= 2'd2;
         else if (key_state == 2'd2 && bus.reg_wdata[7:0] == `EFISP_KEY2)
            key_state <= 2'd3;
         else
            key_state <= 2'd0;
      end
   end

   // Protected control bits; boot select survives software reset
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         prog_en  <= 1'b0;
         boot_sel <= 1'b0;
         app_upd  <= 1'b0;
         cfg_upd  <= 1'b0;
         ldr_upd  <= 1'b0;
      end else if (state == EFISP_LOAD) begin
         boot_sel <= ~cfg_mem[0][`EFISP_CFG_BOOT];
      end else if (wr && unlock && bus.reg_addr == `EFISP_OFS_CTRL) begin
         prog_en  <= bus.reg_wdata[`EFISP_CTRL_EN];
         boot_sel <= bus.reg_wdata[`EFISP_CTRL_BS];
         app_upd  <= bus.reg_wdata[`EFISP_CTRL_APP_UPDATE_ENABLE];
         cfg_upd  <= bus.reg_wdata[`EFISP_CTRL_CFGUEN];
         ldr_upd  <= bus.reg_wdata[`EFISP_CTRL_LDUEN];
      end
   end

   // Fail flag: a new failure wins over a clear in the same cycle
   always_ff @(posedge mclk_i) begin
      if (reset_i)
         prog_fail_flag <= 1'b0;
      else if (go_wr && state == EFISP_IDLE && err)
         prog_fail_flag <= 1'b1;
      else if (wr && unlock && bus.reg_addr == `EFISP_OFS_CTRL
               && bus.reg_wdata[`EFISP_CTRL_FAIL])
         prog_fail_flag <= 1'b0;
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         user_config_o   <= `EFISP_RESET_VAL;
         booted_loader_o <= 1'b0;
      end else if (state == EFISP_LOAD) begin
         user_config_o   <= cfg_mem[0];
         booted_loader_o <= ~cfg_mem[0][`EFISP_CFG_BOOT];
      end else if (bus.sw_reset) begin
         booted_loader_o <= boot_sel;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         prog_address_reg <= `EFISP_RESET_VAL;
         prog_command_reg <= 6'h0;
      end else if (wr && bus.reg_addr == `EFISP_OFS_ADDR) begin
         prog_address_reg <= bus.reg_wdata;
      end else if (wr && bus.reg_addr == `EFISP_OFS_CMD) begin
         prog_command_reg <= bus.reg_wdata[5:0];
      end
   end

   // Command sequencer; registers and fetches stall while it works
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         state       <= EFISP_LOAD;
         prog_go_bit <= 1'b0;
         cnt         <= 17'h0;
         eidx        <= 8'h0;
      end else begin
         case (state)
            EFISP_LOAD: begin
               state <= EFISP_IDLE;
            end
            EFISP_IDLE: begin
               if (go_wr && !err) begin
                  state       <= EFISP_WORK;
                  prog_go_bit <= 1'b1;
                  eidx        <= 8'h0;
                  cnt         <= is_erase ? 17'(ERASE_CYCLES) : is_prog ? PROG_C : READ_C;
               end
            end
            EFISP_WORK: begin
               if (eidx != `EFISP_PAGE_WORDS)
                  eidx <= eidx + 8'h1;
               if (cnt <= 17'h1) begin
                  state       <= EFISP_IDLE;
                  prog_go_bit <= 1'b0;
               end else begin
                  cnt <= cnt - 17'h1;
               end
            end
            default: begin
               state <= EFISP_IDLE;
            end
         endcase
      end
   end

   wire logic last = (state == EFISP_WORK) && (cnt <= 17'h1);
   wire logic erasing = (state == EFISP_WORK) && is_erase && (eidx != `EFISP_PAGE_WORDS);

   // Flash array; erase clears one word per cycle over the page
   always_ff @(posedge mclk_i) begin
      if (erasing && (t_app || t_data))
         main_mem[{a[16:9], eidx[6:0]}] <= `EFISP_ERASED;
      if (erasing && t_ldr)
         ldr_mem[{a[11:9], eidx[6:0]}] <= `EFISP_ERASED;
      if (last && is_prog && (t_app || t_data))
         main_mem[a[16:2]] <= prog_data_reg;
      if (last && is_prog && t_ldr)
         ldr_mem[a[11:2]] <= prog_data_reg;
   end

   // Config words are held as registers so power-on shows the factory word
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         cfg_mem[0] <= CFG_DEFAULT;
         cfg_mem[1] <= CFG_DEFAULT;
      end else if (erasing && t_cfg && eidx == 8'h0) begin
         cfg_mem[0] <= `EFISP_ERASED;
         cfg_mem[1] <= `EFISP_ERASED;
      end else if (last && is_prog && t_cfg) begin
         cfg_mem[a[2]] <= prog_data_reg;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i)
         app_erased <= 1'b0;
      else if (last && is_erase && t_app)
         app_erased <= 1'b1;
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         prog_data_reg <= `EFISP_RESET_VAL;
      end else if (wr && bus.reg_addr == `EFISP_OFS_DATA) begin
         prog_data_reg <= bus.reg_wdata;
      end else if (last && is_cid) begin
         prog_data_reg <= COMPANY_ID;
      end else if (last && is_uid) begin
         prog_data_reg <= UNIQUE_ID[95 - 32 * a[3:2] -: 32];
      end else if (last && is_read) begin
         if (t_cfg)
            prog_data_reg <= cfg_mem[a[2]];
         else if (t_ldr)
            prog_data_reg <= ldr_mem[a[11:2]];
         else
            prog_data_reg <= main_mem[a[16:2]];
      end
   end

   // Fetch path: one registered read per cycle, no wait states while idle; fetches stall while a command runs
   wire logic [31:0] fa = bus.fetch_addr;
   always_ff @(posedge mclk_i) begin
      if (reset_i)
         fdata <= `EFISP_RESET_VAL;
      else if (bus.fetch_req && bus.fetch_ready) begin
         if (fa[31:12] == `EFISP_LDR_TAG || (booted_loader_o && fa[31:12] == 20'h0))
            fdata <= ldr_mem[fa[11:2]];
         else if (fa[31:16] == `EFISP_APP_HI || fa[31:12] == `EFISP_DATA_TAG)
            fdata <= main_mem[fa[16:2]];
         else
            fdata <= `EFISP_RESET_VAL;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         rdata <= `EFISP_RESET_VAL;
      end else if (take) begin
         case (bus.reg_addr)
            `EFISP_OFS_CTRL:  rdata <= {25'h0, prog_fail_flag, ldr_upd, cfg_upd, app_upd,
                                        1'b0, boot_sel, prog_en};
            `EFISP_OFS_ADDR:  rdata <= prog_address_reg;
            `EFISP_OFS_DATA:  rdata <= prog_data_reg;
            `EFISP_OFS_CMD:   rdata <= {26'h0, prog_command_reg};
            `EFISP_OFS_TRIG:  rdata <= {31'h0, prog_go_bit};
            `EFISP_OFS_DBASE: rdata <= `EFISP_DATA_BASE;
            `EFISP_OFS_KEY:   rdata <= {31'h0, unlock};
            default:          rdata <= `EFISP_RESET_VAL;
         endcase
      end
   end

   assign bus.reg_rdata   = rdata;
   assign bus.fetch_data  = fdata;
   assign bus.reg_ready   = (state == EFISP_IDLE);
   assign bus.fetch_ready = (state == EFISP_IDLE);
   assign busy_o          = prog_go_bit;
endmodule : efisp_device

// ### src/efisp_cfg.svh
`ifndef EFISP_CFG_SVH
`define EFISP_CFG_SVH

// Register offsets, byte addresses on the register port
`define EFISP_OFS_CTRL      12'h000
`define EFISP_OFS_ADDR      12'h004
`define EFISP_OFS_DATA      12'h008
`define EFISP_OFS_CMD       12'h00c
`define EFISP_OFS_TRIG      12'h010
`define EFISP_OFS_DBASE     12'h014
`define EFISP_OFS_KEY       12'h100

// Control register fields, trigger go bit and config word boot bit
`define EFISP_CTRL_EN       0
`define EFISP_CTRL_BS       1
`define EFISP_CTRL_APP_UPDATE_ENABLE    3
`define EFISP_CTRL_CFGUEN   4
`define EFISP_CTRL_LDUEN    5
`define EFISP_CTRL_FAIL     6
`define EFISP_TRIG_GO       0
`define EFISP_CFG_BOOT      7

// Write-protect key sequence
`define EFISP_KEY0          8'h59
`define EFISP_KEY1          8'h16
`define EFISP_KEY2          8'h88

// Function codes, with operation enable and chip enable
`define EFISP_FN_READ       4'h0
`define EFISP_FN_PROG       4'h1
`define EFISP_FN_ERASE      4'h2
`define EFISP_FN_UID        4'h4
`define EFISP_FN_CID        4'hb

// Memory map
`define EFISP_APP_HI        16'h0000
`define EFISP_DATA_BASE     32'h0001_f000
`define EFISP_DATA_TAG      20'h0001f
`define EFISP_LDR_TAG       20'h00100
`define EFISP_PAGE_WORDS    8'h80
`define EFISP_ERASED        32'hffff_ffff
`define EFISP_RESET_VAL     32'h0000_0000

// Timing
`define EFISP_CLK_MHZ       50
`define EFISP_READ_NS       40
`define EFISP_PROG_NS       20000
`define EFISP_ERASE_NS      2000000
`define EFISP_READ_CYC      ((`EFISP_READ_NS * `EFISP_CLK_MHZ + 999) / 1000)
`define EFISP_PROG_CYC      ((`EFISP_PROG_NS * `EFISP_CLK_MHZ + 999) / 1000)
`define EFISP_ERASE_CYC     ((`EFISP_ERASE_NS * `EFISP_CLK_MHZ + 999) / 1000)

`endif

// ### src/efisp_pkg.sv
package efisp_pkg;
   typedef enum logic [1:0] {
      EFISP_LOAD,
      EFISP_IDLE,
      EFISP_WORK
   } efisp_dev_state_t;

   typedef enum logic [2:0] {
      EFISP_H_IDLE,
      EFISP_H_ACC,
      EFISP_H_KEY,
      EFISP_H_CHECK,
      EFISP_H_CLEAR
   } efisp_host_state_t;
endpackage : efisp_pkg

// ### src/efisp_if.sv
`timescale 1ns/1ps
interface efisp_if;
   logic        reg_sel;     // Register access request
   logic        reg_we;      // 1 = write
   logic [11:0] reg_addr;    // Byte offset
   logic [31:0] reg_wdata;   // Write data
   logic [31:0] reg_rdata;   // Read data, valid cycle after take
   logic        reg_ready;   // Low while a command runs
   logic        fetch_req;   // Instruction or data fetch
   logic [31:0] fetch_addr;  // Fetch byte address
   logic [31:0] fetch_data;  // Fetch data, cycle after take
   logic        fetch_ready; // Low while a command runs
   logic        sw_reset;    // Software reset pulse

   modport dev (input reg_sel, reg_we, reg_addr, reg_wdata, fetch_req, fetch_addr, sw_reset,
                output reg_rdata, reg_ready, fetch_data, fetch_ready);
   modport host (output reg_sel, reg_we, reg_addr, reg_wdata, fetch_req, fetch_addr, sw_reset,
                 input reg_rdata, reg_ready, fetch_data, fetch_ready);
endinterface : efisp_if

// ### src/efisp_host.sv
`timescale 1ns/1ps
`include "efisp_cfg.svh"
module efisp_host (
   input  wire logic        mclk_i,        // System clock
   input  wire logic        reset_i,       // Synchronous reset
   efisp_if.host            bus,           // Controller side
   input  wire logic        op_req_i,      // Register access request
   input  wire logic        op_we_i,       // 1 = write
   input  wire logic [11:0] op_addr_i,     // Register offset
   input  wire logic [31:0] op_wdata_i,    // Write data
   output logic             op_ready_o,    // Host can take a request
   output logic             op_done_o,     // Access finished pulse
   output logic             op_refused_o,  // Go refused pulse, enable off
   output logic [31:0]      op_rdata_o,    // Read data
   input  wire logic        unlock_i,      // Send key sequence
   input  wire logic        soft_reset_i,  // Software reset request
   input  wire logic        fetch_req_i,   // Fetch request
   input  wire logic [31:0] fetch_addr_i,  // Fetch address
   output logic [31:0]      fetch_data_o,  // Fetch data
   output logic             fetch_valid_o, // Fetch data valid
   output logic             fail_seen_o    // Last command failed
);
   import efisp_pkg::*;

   efisp_host_state_t st;
   logic        sel, we, cap, after_go, en_shadow;
   logic [11:0] addr;
   logic [31:0] wdata;
   logic [1:0]  kidx;

   wire logic taken = sel && bus.reg_ready;
   wire logic go_req = op_we_i && op_addr_i == `EFISP_OFS_TRIG && op_wdata_i[`EFISP_TRIG_GO];

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         st <= EFISP_H_IDLE; sel <= 1'b0; we <= 1'b0; addr <= 12'h0; wdata <= 32'h0;
         kidx <= 2'd0; cap <= 1'b0; after_go <= 1'b0; fail_seen_o <= 1'b0;
         op_done_o <= 1'b0; op_refused_o <= 1'b0; op_rdata_o <= 32'h0; en_shadow <= 1'b0;
      end else begin
         op_done_o    <= 1'b0;
         op_refused_o <= 1'b0;
         cap          <= taken && !we;
         if (cap && st != EFISP_H_CHECK)
            op_rdata_o <= bus.reg_rdata;
         case (st)
            EFISP_H_IDLE: begin
               if (unlock_i) begin
                  st <= EFISP_H_KEY; sel <= 1'b1; we <= 1'b1; addr <= `EFISP_OFS_KEY;
                  wdata <= {24'h0, `EFISP_KEY0}; kidx <= 2'd0;
               end else if (op_req_i && go_req && !en_shadow) begin
                  op_refused_o <= 1'b1;
                  op_done_o    <= 1'b1;
               end else if (op_req_i) begin
                  st <= EFISP_H_ACC; sel <= 1'b1; we <= op_we_i; addr <= op_addr_i;
                  after_go <= go_req;
                  if (go_req)
                     fail_seen_o <= 1'b0;
                  if (op_we_i && op_addr_i == `EFISP_OFS_CTRL)
                     en_shadow <= op_wdata_i[`EFISP_CTRL_EN];
                  wdata <= (op_addr_i == `EFISP_OFS_ADDR) ?
                           {op_wdata_i[31:2], 2'b00} : op_wdata_i;
               end
            end
            EFISP_H_ACC: begin
               // A read stays here until its data is captured, so done marks fresh data
               if (taken) begin
                  sel <= 1'b0;
                  if (after_go) begin
                     st <= EFISP_H_CHECK;
                  end else if (we) begin
                     st <= EFISP_H_IDLE;
                     op_done_o <= 1'b1;
                  end
               end
               if (cap) begin
                  st <= EFISP_H_IDLE;
                  op_done_o <= 1'b1;
               end
            end
            EFISP_H_KEY: begin
               if (taken) begin
                  kidx <= kidx + 2'd1;
                  wdata <= {24'h0, (kidx == 2'd0) ? `EFISP_KEY1 : `EFISP_KEY2};
                  if (kidx == 2'd2) begin
                     sel <= 1'b0; st <= EFISP_H_IDLE; op_done_o <= 1'b1;
                  end
               end
            end
            EFISP_H_CHECK: begin
               // Control read waits until the command has finished
               if (!sel && !cap) begin
                  sel <= 1'b1; we <= 1'b0; addr <= `EFISP_OFS_CTRL;
               end else if (taken) begin
                  sel <= 1'b0;
               end else if (cap) begin
                  if (bus.reg_rdata[`EFISP_CTRL_FAIL]) begin
                     fail_seen_o <= 1'b1;
                     st <= EFISP_H_CLEAR; sel <= 1'b1; we <= 1'b1;
                     wdata <= bus.reg_rdata;
                  end else begin
                     st <= EFISP_H_IDLE; op_done_o <= 1'b1;
                  end
               end
            end
            EFISP_H_CLEAR: begin
               if (taken) begin
                  sel <= 1'b0; st <= EFISP_H_IDLE; op_done_o <= 1'b1;
               end
            end
            default: st <= EFISP_H_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i)
         fetch_valid_o <= 1'b0;
      else
         fetch_valid_o <= fetch_req_i && bus.fetch_ready;
   end

   assign op_ready_o     = (st == EFISP_H_IDLE);
   assign bus.reg_sel    = sel;
   assign bus.reg_we     = we;
   assign bus.reg_addr   = addr;
   assign bus.reg_wdata  = wdata;
   assign bus.fetch_req  = fetch_req_i;
   assign bus.fetch_addr = fetch_addr_i;
   assign bus.sw_reset   = soft_reset_i;
   assign fetch_data_o   = bus.fetch_data;
endmodule : efisp_host

// ### tb/efisp_asserts.sv
`timescale 1ns/1ps
module efisp_asserts (
   input wire logic        mclk_i,     // Clock
   input wire logic        reset_i,    // Reset
   input wire logic        reg_sel,    // Request
   input wire logic        reg_we,     // Write
   input wire logic [11:0] reg_addr,   // Offset
   input wire logic [31:0] reg_rdata,  // Read data
   input wire logic        reg_ready,  // Ready
   input wire logic        fetch_req,  // Fetch
   input wire logic [31:0] fetch_addr, // Fetch address
   input wire logic [31:0] fetch_data, // Fetch data
   input wire logic        fetch_ready // Fetch ready
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   wire logic rd;
   assign rd = reg_sel && reg_ready && !reg_we;
   AST_FETCH_READY: assert property (fetch_ready == reg_ready)
      else $error("fetch ready differs");
   AST_DBASE: assert property (rd && reg_addr == 12'h014 |=> reg_rdata == 32'h0001_f000)
      else $error("data base wrong");
   AST_KEY_BIT: assert property (rd && reg_addr == 12'h100 |=> reg_rdata[31:1] == 31'h0)
      else $error("key read wide");
   AST_STALL_MIN: assert property ($fell(reg_ready) |=> !reg_ready)
      else $error("stall too short");
   AST_STALL_MAX: assert property ($fell(reg_ready) |-> ##[1:1000] reg_ready)
      else $error("stall too long");
   AST_FETCH_OUT: assert property (fetch_req && fetch_ready && fetch_addr == 32'h0002_0000
      |=> fetch_data == 32'h0) else $error("unmapped fetch");
   AST_RDATA_HOLD: assert property (!reg_ready |=> $stable(reg_rdata))
      else $error("read data moved");
   AST_FDATA_HOLD: assert property (!fetch_ready |=> $stable(fetch_data))
      else $error("fetch data moved");
endmodule : efisp_asserts

// ### tb/embedded_flash_isp_controller_tb.sv
`timescale 1ns/1ps
`include "efisp_cfg.svh"
module embedded_flash_isp_controller_tb;
   localparam logic [31:0] CID = 32'h0000_0c3a; // Arbitrary value
   localparam int          ERASE_N = 200;       // Short erase keeps the run brief
   logic        mclk_i = 1'b0, reset_i = 1'b1;
   logic        req = 1'b0, we = 1'b0, unl = 1'b0, srst = 1'b0, freq = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [31:0] wdata = 32'h0, faddr = 32'h0, rdata, fdata, ucfg;
   logic        rdy, done, fail, bootl, busy, refd, fval;
   int          n_fail = 0, check_count = 0, cyc = 0, n_busy = 0, n_refused = 0;
   efisp_if bus ();
   efisp_device #(.ERASE_CYCLES(ERASE_N), .COMPANY_ID(CID)) u_efisp_device (.mclk_i(mclk_i),
      .reset_i(reset_i), .bus(bus), .user_config_o(ucfg), .booted_loader_o(bootl),
      .busy_o(busy));
   efisp_host u_efisp_host (.mclk_i(mclk_i), .reset_i(reset_i), .bus(bus), .op_req_i(req),
      .op_we_i(we), .op_addr_i(addr), .op_wdata_i(wdata), .op_ready_o(rdy), .op_done_o(done),
      .op_refused_o(refd), .op_rdata_o(rdata), .unlock_i(unl), .soft_reset_i(srst),
      .fetch_req_i(freq), .fetch_addr_i(faddr), .fetch_data_o(fdata), .fetch_valid_o(fval),
      .fail_seen_o(fail));
   efisp_asserts u_efisp_asserts (.mclk_i(mclk_i), .reset_i(reset_i), .reg_sel(bus.reg_sel),
      .reg_we(bus.reg_we), .reg_addr(bus.reg_addr), .reg_rdata(bus.reg_rdata),
      .reg_ready(bus.reg_ready), .fetch_req(bus.fetch_req), .fetch_addr(bus.fetch_addr),
      .fetch_data(bus.fetch_data), .fetch_ready(bus.fetch_ready));
   always #10 mclk_i = ~mclk_i;
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : close_out
   // Erase and one program dominate; ceiling leaves ample slack
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         close_out();
      end
   end
   // Busy cycles and refused pulses are counted here because op only waits for its own done pulse
   always @(posedge mclk_i) begin
      if (busy === 1'b1)
         n_busy++;
      if (refd === 1'b1)
         n_refused++;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick();
      @(posedge mclk_i);
      #1;
   endtask : tick
   // Read data is valid with the done pulse; op waits one more cycle
   task automatic op(input logic w, input logic [11:0] a, input logic [31:0] d);
      while (rdy !== 1'b1) tick();
      @(posedge mclk_i);
      req <= 1'b1;
      we <= w;
      addr <= a;
      wdata <= d;
      @(posedge mclk_i);
      req <= 1'b0;
      #1;
      while (done !== 1'b1) tick();
      tick();
   endtask : op
   task automatic run(input logic [31:0] c, input logic [31:0] a);
      op(1'b1, 12'h004, a);
      op(1'b1, 12'h00c, c);
      op(1'b1, 12'h010, 32'h1);
   endtask : run
   task automatic t_regs();
      chk(ucfg, 32'hffff_ffff);
      chk({31'h0, bootl}, 32'h0);
      @(posedge mclk_i);
      unl <= 1'b1;
      @(posedge mclk_i);
      unl <= 1'b0;
      #1;
      while (done !== 1'b1) tick();
      op(1'b1, 12'h000, 32'h9);
      op(1'b0, 12'h000, 32'h0);
      chk(rdata, 32'h9);
      op(1'b0, 12'h014, 32'h0);
      chk(rdata, 32'h0001_f000);
      op(1'b0, 12'h100, 32'h0);
      chk(rdata, 32'h1);
      run(32'h0b, 32'h0);
      op(1'b0, 12'h008, 32'h0);
      chk(rdata, CID);
      $display("regs test done");
   endtask : t_regs
   task automatic t_prog();
      op(1'b1, 12'h008, 32'h1234_abcd);
      run(32'h21, 32'h0001_f000);
      op(1'b1, 12'h008, 32'h0);
      run(32'h00, 32'h0001_f000);
      op(1'b0, 12'h008, 32'h0);
      chk(rdata, 32'h1234_abcd);
      run(32'h22, 32'h0001_f1fc);
      run(32'h00, 32'h0001_f000);
      op(1'b0, 12'h008, 32'h0);
      chk(rdata, 32'hffff_ffff);
      chk({31'h0, fail}, 32'h0);
      chk(n_busy, 32'(3 * `EFISP_READ_CYC + `EFISP_PROG_CYC + ERASE_N));
      $display("prog test done");
   endtask : t_prog
   task automatic t_fail();
      run(32'h21, 32'h0002_0000);
      chk({31'h0, fail}, 32'h1);
      @(posedge mclk_i);
      freq <= 1'b1;
      faddr <= 32'h0001_f000;
      @(posedge mclk_i);
      faddr <= 32'h0002_0000;
      #1;
      chk(fdata, 32'hffff_ffff);
      chk({31'h0, fval}, 32'h1);
      @(posedge mclk_i);
      freq <= 1'b0;
      #1;
      chk(fdata, 32'h0);
      op(1'b1, 12'h000, 32'h3);
      @(posedge mclk_i);
      srst <= 1'b1;
      @(posedge mclk_i);
      srst <= 1'b0;
      tick();
      chk({31'h0, bootl}, 32'h1);
      op(1'b1, 12'h000, 32'h2);
      op(1'b1, 12'h010, 32'h1);
      chk(n_refused, 32'h1);
      $display("fail boot test done");
   endtask : t_fail
   initial begin
      repeat (10) @(posedge mclk_i);
      reset_i <= 1'b0;
      repeat (3) tick();
      t_regs();
      t_prog();
      t_fail();
      close_out();
   end
endmodule : embedded_flash_isp_controller_tb
